// file: bench/bus_master_model.sv
// fieldbus master model that writes and reads drive objects
`timescale 1ns/1ps
module bus_master_model (
  input wire logic mclk,
  input wire logic [15:0] obj_rdata,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata
);
  initial begin
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'hFFFF;
  end

  // called just after an edge; strobe stands for exactly one edge
  task automatic write_word(input logic [15:0] idx, input logic [15:0] data);
    obj_wr = 1'b1;
    obj_index = idx;
    obj_wdata = data;
    @(posedge mclk);
    #1;
    obj_wr = 1'b0;
    // idle lines inverted so a stale word never looks valid
    obj_index = ~idx;
    obj_wdata = ~data;
  endtask

  task automatic read_word(input logic [15:0] idx, output logic [15:0] data);
    obj_index = idx;
    @(posedge mclk);
    #1;
    data = obj_rdata;
    obj_index = ~idx;
    // an edge passes so a following call never reassigns the index in this step
    @(posedge mclk);
    #1;
  endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the drive command and status word state machine
`timescale 1ns/1ps
`include "drive_params.svh"
module tb_top;
  import drive_pkg::*;
  logic mclk, rst_n, obj_wr, init_done, comm_operational, main_power_on, fault_detect, limit_active;
  logic [15:0] obj_index, obj_wdata, obj_rdata, status_word, rd, r, me, ev;
  logic [7:0] op_mode, v, md;
  logic motor_enable, main_power_req, new_setpoint, change_now, abs_rel, halt_req, start_homing;
  int mismatches, n_checks;

  drive_command_status_word_fsm i_dut (.mclk(mclk), .rst_n(rst_n), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .op_mode(op_mode), .init_done(init_done),
    .comm_operational(comm_operational), .main_power_on(main_power_on), .fault_detect(fault_detect),
    .limit_active(limit_active), .trigger_ready(v[0]), .param_zero(v[1]), .setpoint_ack(v[2]),
    .homing_error(v[3]), .target_reached(v[4]), .speed_zero(v[5]), .homing_done(v[6]),
    .following_ok(v[7]), .status_word(status_word), .motor_enable(motor_enable),
    .main_power_req(main_power_req), .new_setpoint(new_setpoint), .change_now(change_now),
    .abs_rel(abs_rel), .halt_req(halt_req), .start_homing(start_homing));

  bus_master_model i_master (.mclk(mclk), .obj_rdata(obj_rdata), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // returns {mask, expected} of the mode-dependent status bits
  function automatic logic [31:0] exp_mode(input logic [7:0] m, input logic [7:0] x);
    case (m)
      `MODE_PP: return {16'hD400, x[0], x[1], 1'b0, x[2], 1'b0, x[4], 10'h000};
      `MODE_PV: return {16'h5400, 1'b0, x[1], 3'b000, x[4], 10'h000};
      `MODE_HM: return {16'hF400, x[0], x[1], x[3], x[6], 1'b0, x[4], 10'h000};
      default: return {16'h1000, 3'b000, x[7], 12'h000};
    endcase
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input logic [15:0] w);
    i_master.write_word(`IDX_CMD_WORD, w);
    tick(2);
  endtask

  // state code only: bit4 reports main power
  function automatic logic [15:0] st();
    return {9'h000, status_word[6:5], 1'b0, status_word[3:0]};
  endfunction

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    n_checks = 0;
    r = 16'hF1DD;
    rst_n = 1'b0;
    init_done = 1'b0;
    comm_operational = 1'b1;
    main_power_on = 1'b1;
    fault_detect = 1'b0;
    limit_active = 1'b0;
    op_mode = `MODE_PP;
    v = 8'h00;
    tick(20);
    rst_n = 1'b1;
    tick(3);
    chk16(st(), 16'h0000);
    init_done = 1'b1;
    tick(3);
    chk16(st(), 16'h0040);
    chk1(status_word[`SB_REMOTE], 1'b1);
    chk1(status_word[`SB_VOLTAGE], 1'b1);
    cmd(16'h000F);
    chk16(st(), 16'h0040);
    r = lfsr_next(r);
    cmd(16'h0006 | (r & 16'hFE00));
    chk16(st(), 16'h0021);
    cmd(16'h0007);
    chk16(st(), 16'h0023);
    chk1(main_power_req, 1'b1);
    cmd(16'h0006);
    chk16(st(), 16'h0021);
    i_master.write_word(`IDX_CMD_WORD, 16'h000F);
    tick(2);
    chk16(st(), 16'h0023);
    tick(1);
    chk16(st(), 16'h0027);
    chk1(motor_enable, 1'b1);
    // mode command bits ride on a word that still means enable operation
    cmd(16'h017F);
    chk16({11'h000, new_setpoint, change_now, abs_rel, halt_req, start_homing}, 16'h001E);
    chk1(status_word[8], 1'b1);
    op_mode = `MODE_HM;
    tick(3);
    chk16({11'h000, new_setpoint, change_now, abs_rel, halt_req, start_homing}, 16'h0003);
    op_mode = `MODE_CSP;
    tick(3);
    chk16({11'h000, new_setpoint, change_now, abs_rel, halt_req, start_homing}, 16'h0000);
    cmd(16'h000F);
    for (int i = 0; i < 12; i++) begin
      r = lfsr_next(r);
      v = r[7:0];
      md = (i % 4 == 0) ? `MODE_PP : (i % 4 == 1) ? `MODE_PV : (i % 4 == 2) ? `MODE_HM : `MODE_CSP;
      op_mode = md;
      tick(3);
      {me, ev} = exp_mode(md, v);
      chk16(status_word & me, ev);
    end
    op_mode = `MODE_PP;
    cmd(16'h0002);
    chk16(st(), 16'h0007);
    chk1(status_word[`SB_QUICK_STOP], 1'b0);
    chk1(status_word[8], 1'b1);
    cmd(16'h000F);
    chk16(st(), 16'h0027);
    cmd(16'h0000);
    chk16(st(), 16'h0040);
    chk1(motor_enable, 1'b0);
    // following must drop once the drive is disabled
    op_mode = `MODE_CSP;
    v = 8'h80;
    tick(3);
    chk1(status_word[12], 1'b0);
    // speed zero only counts during a halt or a limit
    op_mode = `MODE_PV;
    v = 8'h20;
    tick(3);
    chk1(status_word[12], 1'b0);
    limit_active = 1'b1;
    main_power_on = 1'b0;
    tick(3);
    chk1(status_word[`SB_LIMIT], 1'b1);
    chk1(status_word[8], 1'b1);
    chk1(status_word[12], 1'b1);
    chk1(status_word[`SB_VOLTAGE], 1'b0);
    limit_active = 1'b0;
    main_power_on = 1'b1;
    comm_operational = 1'b0;
    tick(3);
    chk1(status_word[`SB_REMOTE], 1'b0);
    cmd(16'h0006);
    chk16(st(), 16'h0040);
    comm_operational = 1'b1;
    cmd(16'h0080);
    fault_detect = 1'b1;
    tick(1);
    fault_detect = 1'b0;
    tick(1);
    chk16(st(), 16'h000F);
    tick(1);
    chk16(st(), 16'h0008);
    tick(3);
    chk16(st(), 16'h0008);
    cmd(16'h0000);
    cmd(16'h0080);
    chk16(st(), 16'h0040);
    i_master.read_word(`IDX_CMD_WORD, rd);
    chk16(rd, 16'h0080);
    i_master.read_word(`IDX_STATE_WORD, rd);
    chk16({9'h000, rd[6:5], 1'b0, rd[3:0]}, 16'h0040);
    chk1(rd[`SB_VOLTAGE], 1'b1);
    i_master.read_word(16'h1234, rd);
    chk16(rd, 16'h0000);
    finish_test();
  end
endmodule

// file: hw/drive_command_status_word_fsm.sv
// drive power state machine with command word decode and status word encode
// Notes on behaviour
// (R1) command bits: switch-on, voltage, quick stop low, enable op, mode bits, fault reset, halt
// (R2) shutdown 0006h, switch-on 0007h, enable op 000Fh, disable voltage clears bit1
// (R3) 000Fh from ready passes through switched on then operation enabled
// (R4) bit2 low with bit1 high is quick stop; operation enabled goes to quick stop active
// (R5) fault reports 08h and leaves only on a rising edge of fault reset
// (R6) mode bits: pp setpoint/immediate/abs-rel/halt, pv halt, homing start/halt, csp none
// (R7) status bits: ready, on, enabled, fault, voltage, quick stop, disabled, remote, limit
// (R8) state encoded on status bits 6, 5 and 3-0 with the listed codes
// (R9) detected error enters fault reaction active, reporting 0Fh with bit6 low
// (R10) status bit4 follows main circuit power
// (R11) status bit5 is low while quick stop is active
// (R12) without operational communication, bit9 stays low and commands are ignored
// (R13) status bit11 set while a hardware limit is active
// (R14) pp mode status bits 15, 14, 12, 10; pv mode bits 14, 12, 10; csp mode bit 12 only
// (R15) homing mode status bits 15, 14, 13, 12, 10
// (R16) status bit8 set on limit, halt or quick stop
// (R17) csp bit12 follows master, cleared when disabled
// (R18) pv bit12 valid only during halt or limit
// (R19) not ready moves to switch-on disabled after initialisation, unprompted
// (R20) fault reaction disables the motor and moves to fault unprompted
// (R21) a command with no allowed transition leaves the state unchanged
`timescale 1ns/1ps
`include "drive_params.svh"
module drive_command_status_word_fsm
  import drive_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire drive_pkg::word_t obj_wdata,
  output drive_pkg::word_t obj_rdata,
  input wire logic [7:0] op_mode,
  input wire logic init_done,
  input wire logic comm_operational,
  input wire logic main_power_on,
  input wire logic fault_detect,
  input wire logic limit_active,
  input wire logic trigger_ready,
  input wire logic param_zero,
  input wire logic setpoint_ack,
  input wire logic target_reached,
  input wire logic speed_zero,
  input wire logic homing_done,
  input wire logic homing_error,
  input wire logic following_ok,
  output drive_pkg::word_t status_word,
  output logic motor_enable,
  output logic main_power_req,
  output logic new_setpoint,
  output logic change_now,
  output logic abs_rel,
  output logic halt_req,
  output logic start_homing
);
  import drive_pkg::*;

  // ---------------------------------------------
  // command word
  // ---------------------------------------------
  word_t cmd_word;
  drive_state_e state;
  drive_state_e next_state;
  word_t next_status;
  word_t next_rdata;
  logic [15:0] mode_bits;
  logic reset_rise;

  // writes while not operational are dropped; see (R12)
  wire cmd_wr = obj_wr & (obj_index == `IDX_CMD_WORD) & comm_operational;
  wire [15:0] next_cmd = cmd_wr ? obj_wdata : cmd_word;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_word <= `CMD_RESET;
    end else begin
      cmd_word <= next_cmd;
    end
  end

  // bits 15-9 carry nothing; see (R1)
  wire c_on = cmd_word[`CB_SWITCH_ON];
  wire c_volt = cmd_word[`CB_VOLTAGE];
  wire c_qs_n = cmd_word[`CB_QUICK_STOP];
  wire c_enop = cmd_word[`CB_ENABLE_OP];
  wire c_frst = cmd_word[`CB_FAULT_RESET];
  wire c_halt = cmd_word[`CB_HALT];

  // transition commands from bit7 and bits 3-0; see (R2)
  wire do_shutdown = ~c_frst & c_qs_n & c_volt & ~c_on;
  wire do_switch_on = ~c_frst & ~c_enop & c_qs_n & c_volt & c_on;
  wire do_enable_op = ~c_frst & c_enop & c_qs_n & c_volt & c_on;
  wire do_disable_v = ~c_frst & ~c_volt;
  // active-low quick stop; see (R4)
  wire do_quick_stop = ~c_frst & ~c_qs_n & c_volt;
  wire go = comm_operational;

  // fault reset acts on an edge only; see (R5)
  rise_detect u_reset_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .level(c_frst),
    .rise(reset_rise)
  );

  // ---------------------------------------------
  // power state machine
  // ---------------------------------------------
  wire can_fault = (state != ST_FAULT_REACT) & (state != ST_FAULT);

  always_comb begin
    next_state = state;
    // unmatched commands fall through with state kept; see (R21)
    if (fault_detect && can_fault) begin
      next_state = ST_FAULT_REACT; // see (R9)
    end else begin
      case (state)
        ST_NOT_READY: begin
          if (init_done) begin
            next_state = ST_SOD; // see (R19)
          end
        end
        ST_SOD: begin
          if (go && do_shutdown) begin
            next_state = ST_READY;
          end
        end
        ST_READY: begin
          // 000Fh lands in switched on first; see (R3)
          if (go && (do_switch_on || do_enable_op)) begin
            next_state = ST_SWITCHED_ON;
          end else if (go && (do_disable_v || do_quick_stop)) begin
            next_state = ST_SOD;
          end
        end
        ST_SWITCHED_ON: begin
          if (go && do_enable_op) begin
            next_state = ST_OP_ENABLED; // see (R3)
          end else if (go && do_shutdown) begin
            next_state = ST_READY;
          end else if (go && (do_disable_v || do_quick_stop)) begin
            next_state = ST_SOD;
          end
        end
        ST_OP_ENABLED: begin
          if (go && do_switch_on) begin
            next_state = ST_SWITCHED_ON;
          end else if (go && do_shutdown) begin
            next_state = ST_READY;
          end else if (go && do_disable_v) begin
            next_state = ST_SOD;
          end else if (go && do_quick_stop) begin
            next_state = ST_QS_ACTIVE; // see (R4)
          end
        end
        ST_QS_ACTIVE: begin
          if (go && do_disable_v) begin
            next_state = ST_SOD;
          end else if (go && do_enable_op) begin
            next_state = ST_OP_ENABLED;
          end
        end
        ST_FAULT_REACT: begin
          // motor_enable clears on the same edge that moves on to fault; see (R20)
          next_state = ST_FAULT;
        end
        ST_FAULT: begin
          if (go && reset_rise) begin
            next_state = ST_SOD; // see (R5)
          end
        end
        default: begin
          next_state = ST_NOT_READY;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------
  // status word
  // ---------------------------------------------
  wire in_op = (state == ST_OP_ENABLED);
  wire in_qs = (state == ST_QS_ACTIVE);
  wire mode_pp = (op_mode == `MODE_PP);
  wire mode_pv = (op_mode == `MODE_PV);
  wire mode_hm = (op_mode == `MODE_HM);
  // csp ignores halt; see (R6)
  wire halt_used = c_halt & (mode_pp | mode_pv | mode_hm);

  mode_status_mux u_mode_bits (
    .op_mode(op_mode),
    .op_enabled(in_op),
    .qs_active(in_qs),
    .halt(halt_used),
    .limit_active(limit_active),
    .trigger_ready(trigger_ready),
    .param_zero(param_zero),
    .setpoint_ack(setpoint_ack),
    .target_reached(target_reached),
    .speed_zero(speed_zero),
    .homing_done(homing_done),
    .homing_error(homing_error),
    .following_ok(following_ok),
    .mode_bits(mode_bits)
  );

  logic [6:0] state_code;
  always_comb begin
    // see (R8)
    case (state)
      ST_NOT_READY: state_code = `SC_NOT_READY;
      ST_SOD: state_code = `SC_SOD;
      ST_READY: state_code = `SC_READY;
      ST_SWITCHED_ON: state_code = `SC_SWITCHED_ON;
      ST_OP_ENABLED: state_code = `SC_OP_ENABLED;
      ST_QS_ACTIVE: state_code = `SC_QS_ACTIVE; // bit5 low; see (R11)
      ST_FAULT_REACT: state_code = `SC_FAULT_REACT; // see (R9)
      ST_FAULT: state_code = `SC_FAULT; // see (R5)
      default: state_code = `SC_NOT_READY;
    endcase
  end

  always_comb begin
    // see (R7)
    next_status = mode_bits;
    next_status[6:5] = state_code[6:5];
    next_status[3:0] = state_code[3:0];
    next_status[`SB_VOLTAGE] = main_power_on; // see (R10)
    next_status[`SB_REMOTE] = comm_operational; // see (R12)
    next_status[`SB_LIMIT] = limit_active; // see (R13)
  end

  assign next_rdata = (obj_index == `IDX_CMD_WORD) ? cmd_word :
                      (obj_index == `IDX_STATE_WORD) ? next_status : 16'h0000;

  // ---------------------------------------------
  // registered outputs
  // ---------------------------------------------
  wire power_states = in_op | in_qs | (state == ST_SWITCHED_ON);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_word <= 16'h0000;
      obj_rdata <= 16'h0000;
      motor_enable <= 1'b0;
      main_power_req <= 1'b0;
      new_setpoint <= 1'b0;
      change_now <= 1'b0;
      abs_rel <= 1'b0;
      halt_req <= 1'b0;
      start_homing <= 1'b0;
    end else begin
      status_word <= next_status;
      obj_rdata <= next_rdata;
      motor_enable <= in_op | in_qs; // reaction state drops it; see (R20)
      main_power_req <= power_states;
      new_setpoint <= mode_pp & cmd_word[`CB_NEW_SETPOINT]; // see (R6)
      change_now <= mode_pp & cmd_word[`CB_CHANGE_NOW]; // see (R6)
      abs_rel <= mode_pp & cmd_word[`CB_ABS_REL]; // see (R6)
      halt_req <= halt_used; // see (R6)
      start_homing <= mode_hm & cmd_word[`CB_NEW_SETPOINT]; // see (R6)
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  // bit4 reports main power, not the state, so it is kept out of the code
  wire [6:0] shown_code = status_word[6:0] & 7'h6F;

  AST_CMD_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n) // see (R12)
    (!comm_operational && obj_wr) |=> $stable(cmd_word))
    else $error("command written while not operational");

  AST_INIT_MOVE: assert property (@(posedge mclk) disable iff (!rst_n) // see (R19)
    (state == ST_NOT_READY && init_done && !fault_detect) |=> (state == ST_SOD))
    else $error("no move to switch-on disabled after init");

  AST_READY_PASS: assert property (@(posedge mclk) disable iff (!rst_n) // see (R3)
    (state == ST_READY && go && do_enable_op && !fault_detect) |=> (state == ST_SWITCHED_ON))
    else $error("ready did not pass through switched on");

  AST_QS_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n) // see (R4)
    (in_op && go && do_quick_stop && !fault_detect) |=> in_qs ##1 !status_word[`SB_QUICK_STOP])
    else $error("quick stop not entered or bit5 high");

  AST_REACT_TO_FAULT: assert property (@(posedge mclk) disable iff (!rst_n) // see (R20)
    (state == ST_FAULT_REACT) |=> (state == ST_FAULT) && !motor_enable ##1 (shown_code == `SC_FAULT))
    else $error("fault reaction did not end in fault");

  AST_FAULT_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n) // see (R5)
    (state == ST_FAULT && !reset_rise) |=> (state == ST_FAULT))
    else $error("fault left without a reset edge");

  AST_FAULT_EDGE: assert property (@(posedge mclk) disable iff (!rst_n) // see (R5)
    (state == ST_FAULT && reset_rise && go) |=> (state == ST_SOD))
    else $error("fault reset edge not honoured");

  AST_ERROR_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n) // see (R9)
    (fault_detect && can_fault) |=> ##1 (shown_code == `SC_FAULT_REACT))
    else $error("error did not report fault reaction");

  AST_OP_CODE: assert property (@(posedge mclk) disable iff (!rst_n) // see (R8)
    in_op |=> (shown_code == `SC_OP_ENABLED))
    else $error("operation enabled code wrong");

  AST_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n) // see (R10) (R13)
    1'b1 |=> (status_word[`SB_VOLTAGE] == $past(main_power_on)) && (status_word[`SB_LIMIT] == $past(limit_active)))
    else $error("power or limit flag wrong");

  AST_REMOTE: assert property (@(posedge mclk) disable iff (!rst_n) // see (R12)
    !comm_operational |=> !status_word[`SB_REMOTE])
    else $error("remote bit set while not operational");

  AST_ABNORMAL: assert property (@(posedge mclk) disable iff (!rst_n) // see (R16)
    (limit_active || in_qs) |=> status_word[8])
    else $error("abnormal stop bit missing");

  AST_NO_MATCH: assert property (@(posedge mclk) disable iff (!rst_n) // see (R21)
    (state == ST_SOD && !do_shutdown && !fault_detect) |=> (state == ST_SOD))
    else $error("state moved without a matching command");

  AST_SHUTDOWN: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
    (state == ST_SOD && go && do_shutdown && !fault_detect) |=> (state == ST_READY))
    else $error("shutdown did not reach ready");

  AST_DISABLE_V: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
    (power_states && go && do_disable_v && !fault_detect) |=> (state == ST_SOD))
    else $error("disable voltage did not reach switch-on disabled");

  AST_OP_PASS: assert property (@(posedge mclk) disable iff (!rst_n) // see (R3)
    (state == ST_SWITCHED_ON && go && do_enable_op && !fault_detect) |=> in_op)
    else $error("switched on did not move on to operation enabled");

  AST_QS_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // see (R11)
    in_qs |=> !status_word[`SB_QUICK_STOP])
    else $error("quick stop flag high while quick stop active");

  AST_HALT_STOP: assert property (@(posedge mclk) disable iff (!rst_n) // see (R16)
    halt_used |=> status_word[8])
    else $error("abnormal stop bit missing during halt");
endmodule

// file: hw/drive_params.svh
// object indices, command and status bit positions, state codes
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH
`define IDX_CMD_WORD 16'h6040
`define IDX_STATE_WORD 16'h6041
`define CMD_RESET 16'h0000
`define CB_SWITCH_ON 0
`define CB_VOLTAGE 1
`define CB_QUICK_STOP 2
`define CB_ENABLE_OP 3
`define CB_NEW_SETPOINT 4
`define CB_CHANGE_NOW 5
`define CB_ABS_REL 6
`define CB_FAULT_RESET 7
`define CB_HALT 8
`define SB_VOLTAGE 4
`define SB_QUICK_STOP 5
`define SB_REMOTE 9
`define SB_LIMIT 11
`define SC_NOT_READY 7'h00
`define SC_SOD 7'h40
`define SC_READY 7'h21
`define SC_SWITCHED_ON 7'h23
`define SC_OP_ENABLED 7'h27
`define SC_QS_ACTIVE 7'h07
`define SC_FAULT_REACT 7'h0F
`define SC_FAULT 7'h08
`define MODE_PP 8'h01
`define MODE_PV 8'h03
`define MODE_HM 8'h06
`define MODE_CSP 8'h08
`endif

// file: hw/drive_pkg.sv
// types shared by the drive state machine files
package drive_pkg;
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SOD = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP_ENABLED = 8'h10,
    ST_QS_ACTIVE = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_e;
  typedef logic [15:0] word_t;
endpackage

// file: hw/mode_status_mux.sv
// mode-dependent status bits 15-12, 10 and 8
`timescale 1ns/1ps
`include "drive_params.svh"
module mode_status_mux (
  input wire logic [7:0] op_mode,
  input wire logic op_enabled,
  input wire logic qs_active,
  input wire logic halt,
  input wire logic limit_active,
  input wire logic trigger_ready,
  input wire logic param_zero,
  input wire logic setpoint_ack,
  input wire logic target_reached,
  input wire logic speed_zero,
  input wire logic homing_done,
  input wire logic homing_error,
  input wire logic following_ok,
  output logic [15:0] mode_bits
);
  wire is_pp = (op_mode == `MODE_PP);
  wire is_pv = (op_mode == `MODE_PV);
  wire is_hm = (op_mode == `MODE_HM);
  wire is_csp = (op_mode == `MODE_CSP);
  // abnormal stop / quick stop flag in every mode; see (R16)
  wire abnormal = limit_active | halt | qs_active;
  // pv speed-zero only counts during a halt or a limit; see (R18)
  wire pv_zero = speed_zero & (halt | limit_active);
  // csp following drops once the drive is disabled; see (R17)
  wire csp_follow = following_ok & op_enabled;
  wire b15 = (is_pp | is_hm) & trigger_ready;
  wire b14 = (is_pp | is_pv | is_hm) & param_zero;
  wire b13 = is_hm & homing_error;
  wire b12 = (is_pp & setpoint_ack) | (is_pv & pv_zero) | (is_hm & homing_done) | (is_csp & csp_follow);
  wire b10 = (is_pp | is_pv | is_hm) & target_reached;
  // see (R14) (R15)
  assign mode_bits = {b15, b14, b13, b12, 1'b0, b10, 1'b0, abnormal, 8'h00};
endmodule

// file: hw/rise_detect.sv
// rising edge detector for a synchronous level
`timescale 1ns/1ps
module rise_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise
);
  logic prev;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end
  assign rise = level & ~prev;
endmodule
